// ==== hw/logical_device_config_bank.sv ====
// per logical device configuration register bank behind index and data ports
// How it works
// [RL1] keyboard irq select 0x70 clears on all resets
// [RL2] pointer irq select 0x72 clears on all resets
// [RL3] infrared timeout 0xF2 loads 0x03, survives soft
// [RL4] routing 0xF4/0xF5 clear on standby reset only
// [RL5] four expansion windows, high/low bytes 0x60-0x67
// [RL6] locked window ignores writes to its bytes
// [RL7] lock bit cleared by power/hard/standby resets only
// [RL8] expansion select bit7 hard reset, whole standby
// [RL9] reserved locations read zero, are read-only
// [RL10] index then data, only in configuration mode
// [RL11] device number 0x07 selects addressed device
// [RL12] bit0 of 0x02 soft-resets, then self-clears
// [RL13] unimplemented registers ignore writes, read zero
// [RL14] unspecified soft value keeps contents on soft
`timescale 1ns/10ps
`include "ldcfg_defs.svh"

module logical_device_config_bank
    import ldcfg_pkg::*;
#(
    parameter int DEVICE_ID  = 8'h5A,  // arbitrary value
    parameter int DEVICE_REV = 8'h01   // arbitrary value
) (
    input  wire logic                      i_clk_sys,
    input  wire logic                      i_nrst,
    input  wire logic                      i_main_por,
    input  wire logic                      i_hard_rst,
    input  wire logic                      i_wr,
    input  wire logic                      i_rd,
    input  wire logic                      i_port_sel,
    input  wire logic [7:0]                i_wdata,
    output logic      [7:0]                o_rdata,
    output logic                           o_config_mode,
    output logic                           o_soft_reset,
    output logic      [7:0]                o_ldn,
    output logic      [`NUM_LDN-1:0]       o_active,
    output logic      [`NUM_SLOTS*8-1:0]   o_slot_values
);

    if (DEVICE_ID < 0 || DEVICE_ID > 255 || DEVICE_REV < 0 || DEVICE_REV > 255) begin : g_bad_id
        $error("identity parameters must fit eight bits");
    end

    // [RL5] slot table, expansion windows at 0x60-0x67
    localparam slot_s SLOTS [`NUM_SLOTS] = '{
        '{`LD_FLOPPY,    `IDX_OPT_A,      `RV_ZERO,       `MASK_ALL,  `MASK_NONE,     `WIN_NONE},
        '{`LD_FLOPPY,    `IDX_OPT_B,      `RV_ZERO,       `MASK_ALL,  `MASK_NONE,     `WIN_NONE},
        '{`LD_PARALLEL,  `IDX_ACTIVATE,   `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      `WIN_NONE},
        '{`LD_PARALLEL,  `IDX_BASE0_HI,   `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      `WIN_NONE},
        '{`LD_PARALLEL,  `IDX_BASE0_LO,   `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      `WIN_NONE},
        '{`LD_PARALLEL,  `IDX_IRQ1,       `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      `WIN_NONE},
        '{`LD_PARALLEL,  `IDX_DMA,        `RV_DMA_PAR,    `MASK_ALL,  `MASK_ALL,      `WIN_NONE},
        '{`LD_PARALLEL,  `IDX_MODE,       `RV_PAR_MODE,   `MASK_ALL,  `MASK_NONE,     `WIN_NONE},
        '{`LD_PARALLEL,  `IDX_MODE2,      `RV_ZERO,       `MASK_ALL,  `MASK_NONE,     `WIN_NONE},
        '{`LD_SERIAL1,   `IDX_ACTIVATE,   `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      `WIN_NONE},
        '{`LD_SERIAL1,   `IDX_BASE0_HI,   `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      `WIN_NONE},
        '{`LD_SERIAL1,   `IDX_BASE0_LO,   `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      `WIN_NONE},
        '{`LD_SERIAL1,   `IDX_IRQ1,       `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      `WIN_NONE},
        '{`LD_SERIAL1,   `IDX_MODE,       `RV_ZERO,       `MASK_ALL,  `MASK_NONE,     `WIN_NONE},
        '{`LD_SERIAL2,   `IDX_ACTIVATE,   `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      `WIN_NONE},
        '{`LD_SERIAL2,   `IDX_BASE0_HI,   `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      `WIN_NONE},
        '{`LD_SERIAL2,   `IDX_BASE0_LO,   `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      `WIN_NONE},
        '{`LD_SERIAL2,   `IDX_IRQ1,       `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      `WIN_NONE},
        '{`LD_SERIAL2,   `IDX_MODE,       `RV_ZERO,       `MASK_ALL,  `MASK_NONE,     `WIN_NONE},
        '{`LD_SERIAL2,   `IDX_MODE2,      `RV_IR_OPTIONS, `MASK_ALL,  `MASK_NONE,     `WIN_NONE},
        // [RL3] timeout keeps on soft
        '{`LD_SERIAL2,   `IDX_IR_TIMEOUT, `RV_IR_TIMEOUT, `MASK_ALL,  `MASK_NONE,     `WIN_NONE},
        '{`LD_KEYBOARD,  `IDX_ACTIVATE,   `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      `WIN_NONE},
        // [RL1] [RL2] interrupt selects clear always
        '{`LD_KEYBOARD,  `IDX_IRQ1,       `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      `WIN_NONE},
        '{`LD_KEYBOARD,  `IDX_IRQ2,       `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      `WIN_NONE},
        '{`LD_KEYBOARD,  `IDX_MODE,       `RV_ZERO,       `MASK_ALL,  `MASK_NONE,     `WIN_NONE},
        '{`LD_EXPANSION, `IDX_ACTIVATE,   `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      `WIN_NONE},
        '{`LD_EXPANSION, `IDX_BASE0_HI,   `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      3'h1},
        '{`LD_EXPANSION, `IDX_BASE0_LO,   `RV_ZERO,       `MASK_ALL,  `MASK_LOW_SOFT, 3'h1},
        '{`LD_EXPANSION, `IDX_BASE1_HI,   `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      3'h2},
        '{`LD_EXPANSION, `IDX_BASE1_LO,   `RV_ZERO,       `MASK_ALL,  `MASK_LOW_SOFT, 3'h2},
        '{`LD_EXPANSION, `IDX_BASE2_HI,   `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      3'h3},
        '{`LD_EXPANSION, `IDX_BASE2_LO,   `RV_ZERO,       `MASK_ALL,  `MASK_LOW_SOFT, 3'h3},
        '{`LD_EXPANSION, `IDX_BASE3_HI,   `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      3'h4},
        '{`LD_EXPANSION, `IDX_BASE3_LO,   `RV_ZERO,       `MASK_ALL,  `MASK_LOW_SOFT, 3'h4},
        // [RL8] bit7 hard mask
        '{`LD_EXPANSION, `IDX_MODE,       `RV_ZERO,       `MASK_BIT7, `MASK_NONE,     `WIN_NONE},
        '{`LD_RUNTIME,   `IDX_ACTIVATE,   `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      `WIN_NONE},
        '{`LD_RUNTIME,   `IDX_BASE0_HI,   `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      `WIN_NONE},
        '{`LD_RUNTIME,   `IDX_BASE0_LO,   `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      `WIN_NONE},
        // [RL4] standby-only registers
        '{`LD_RUNTIME,   `IDX_MODE,       `RV_ZERO,       `MASK_NONE, `MASK_NONE,     `WIN_NONE},
        '{`LD_RUNTIME,   `IDX_OPT_A,      `RV_ZERO,       `MASK_NONE, `MASK_NONE,     `WIN_NONE},
        '{`LD_RUNTIME,   `IDX_OPT_B,      `RV_ZERO,       `MASK_NONE, `MASK_NONE,     `WIN_NONE},
        '{`LD_SYSMGMT,   `IDX_ACTIVATE,   `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      `WIN_NONE},
        '{`LD_SYSMGMT,   `IDX_BASE0_HI,   `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      `WIN_NONE},
        '{`LD_SYSMGMT,   `IDX_BASE0_LO,   `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      `WIN_NONE},
        '{`LD_SYSMGMT,   `IDX_IRQ1,       `RV_ZERO,       `MASK_ALL,  `MASK_ALL,      `WIN_NONE}
    };

    function automatic int find_slot(input logic [7:0] ld, input logic [7:0] ix);
        int found;
        found = 0;
        for (int k = 0; k < `NUM_SLOTS; k++) begin
            if (SLOTS[k].ldn == ld && SLOTS[k].idx == ix) begin
                found = k;
            end
        end
        return found;
    endfunction : find_slot

    localparam int S_KBD_IRQ  = find_slot(`LD_KEYBOARD, `IDX_IRQ1);
    localparam int S_PTR_IRQ  = find_slot(`LD_KEYBOARD, `IDX_IRQ2);
    localparam int S_IR_TMO   = find_slot(`LD_SERIAL2, `IDX_IR_TIMEOUT);
    localparam int S_ROUTE1   = find_slot(`LD_RUNTIME, `IDX_OPT_A);
    localparam int S_ROUTE2   = find_slot(`LD_RUNTIME, `IDX_OPT_B);
    localparam int S_WIN0_HI  = find_slot(`LD_EXPANSION, `IDX_BASE0_HI);
    localparam int S_WIN0_LO  = find_slot(`LD_EXPANSION, `IDX_BASE0_LO);
    localparam int S_XBUS_SEL = find_slot(`LD_EXPANSION, `IDX_MODE);

    cfg_state_e                    state;
    cfg_state_e                    next_state;
    logic [7:0]                    index;
    logic [7:0]                    next_index;
    logic [7:0]                    ldn;
    logic [7:0]                    next_ldn;
    logic                          soft_pulse;
    logic                          next_soft_pulse;
    logic [7:0]                    rdata;
    logic [7:0]                    next_rdata;
    logic [`NUM_SLOTS-1:0][7:0]    slot_q;
    logic [`NUM_SLOTS-1:0][7:0]    next_slot;
    logic [`NUM_SLOTS-1:0]         slot_hit;
    logic [`NUM_SLOTS-1:0]         slot_we;
    logic [`NUM_WINDOWS:0]         win_lock;
    logic [7:0]                    slot_rd;
    logic                          hm_rst;
    logic                          data_wr;
    logic                          data_rd;

    assign hm_rst  = i_main_por | i_hard_rst;
    // [RL10] data port only acts in configuration mode
    assign data_wr = i_wr && i_port_sel == `PORT_DATA && state == ST_CONFIG;
    assign data_rd = i_rd && i_port_sel == `PORT_DATA && state == ST_CONFIG;

    // [RL6] lock bit of each window's low byte
    always_comb begin
        win_lock = '0;
        for (int k = 0; k < `NUM_SLOTS; k++) begin
            if (SLOTS[k].win != `WIN_NONE && SLOTS[k].idx[0]) begin
                win_lock[SLOTS[k].win] = slot_q[k][`BIT_WRITE_LOCK];
            end
        end
    end

    // [RL11] device number picks the addressed slot
    always_comb begin
        // [RL13] no hit: no write, zero read
        slot_rd = '0;
        for (int k = 0; k < `NUM_SLOTS; k++) begin
            slot_hit[k] = SLOTS[k].ldn == ldn && SLOTS[k].idx == index;
            slot_we[k]  = data_wr && slot_hit[k]
                          && !(SLOTS[k].win != `WIN_NONE && win_lock[SLOTS[k].win]);
            slot_rd     = slot_rd | (slot_hit[k] ? slot_q[k] : 8'h00);
        end
    end

    generate
        for (genvar g = 0; g < `NUM_SLOTS; g++) begin : g_slot
            always_comb begin
                next_slot[g] = slot_we[g] ? i_wdata : slot_q[g];
                // [RL14] masks keep bits with no soft value
                if (soft_pulse) begin
                    next_slot[g] = (next_slot[g] & ~SLOTS[g].soft_mask)
                                   | (SLOTS[g].rst & SLOTS[g].soft_mask);
                end
                // [RL7] hard and main power masks
                if (hm_rst) begin
                    next_slot[g] = (next_slot[g] & ~SLOTS[g].hm_mask)
                                   | (SLOTS[g].rst & SLOTS[g].hm_mask);
                end
            end
            // standby reset reloads every slot
            always_ff @(posedge i_clk_sys) begin
                if (!i_nrst) begin
                    slot_q[g] <= SLOTS[g].rst;
                end else begin
                    slot_q[g] <= next_slot[g];
                end
            end
        end
    endgenerate

    always_comb begin
        next_state      = state;
        next_index      = index;
        next_ldn        = ldn;
        next_soft_pulse = 1'b0;
        next_rdata      = rdata;
        // [RL10] enter and exit keys on the index port
        if (i_wr && i_port_sel == `PORT_INDEX) begin
            case (state)
                ST_RUN: begin
                    if (i_wdata == `KEY_ENTER) begin
                        next_state = ST_CONFIG;
                    end
                end
                ST_CONFIG: begin
                    if (i_wdata == `KEY_EXIT) begin
                        next_state = ST_RUN;
                    end else begin
                        next_index = i_wdata;
                    end
                end
                default: begin
                    next_state = ST_RUN;
                end
            endcase
        end
        // [RL11] device number write
        if (data_wr && index == `IDX_LDN) begin
            next_ldn = i_wdata;
        end
        // [RL12] one-cycle soft reset, bit never stored
        if (data_wr && index == `IDX_CFG_CTRL) begin
            next_soft_pulse = i_wdata[`BIT_SOFT_RESET];
        end
        if (i_rd) begin
            next_rdata = 8'h00;
            if (state == ST_CONFIG && i_port_sel == `PORT_INDEX) begin
                next_rdata = index;
            end else if (data_rd) begin
                // [RL9] reserved and global gaps return zero
                if (index >= `IDX_DEV_FIRST) begin
                    next_rdata = slot_rd;
                end else if (index == `IDX_LDN) begin
                    next_rdata = ldn;
                end else if (index == `IDX_DEV_ID) begin
                    next_rdata = DEVICE_ID[7:0];
                end else if (index == `IDX_DEV_REV) begin
                    next_rdata = DEVICE_REV[7:0];
                end
            end
        end
        if (soft_pulse) begin
            next_ldn = `LD_FLOPPY;
        end
        if (hm_rst) begin
            next_state      = ST_RUN;
            next_index      = 8'h00;
            next_ldn        = `LD_FLOPPY;
            next_soft_pulse = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            state      <= ST_RUN;
            index      <= 8'h00;
            ldn        <= `LD_FLOPPY;
            soft_pulse <= 1'b0;
            rdata      <= 8'h00;
        end else begin
            state      <= next_state;
            index      <= next_index;
            ldn        <= next_ldn;
            soft_pulse <= next_soft_pulse;
            rdata      <= next_rdata;
        end
    end

    // activate bit of each device except the floppy feeds its enable
    always_comb begin
        o_active = '0;
        for (int k = 0; k < `NUM_SLOTS; k++) begin
            if (SLOTS[k].idx == `IDX_ACTIVATE) begin
                o_active[SLOTS[k].ldn[3:0]] = slot_q[k][`BIT_ACTIVE];
            end
        end
    end

    assign o_rdata       = rdata;
    assign o_config_mode = state == ST_CONFIG;
    assign o_soft_reset  = soft_pulse;
    assign o_ldn         = ldn;
    assign o_slot_values = slot_q;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    a_kbd_irq_soft: assert property (soft_pulse |=> slot_q[S_KBD_IRQ] == `RV_ZERO) // [RL1]
        else $error("keyboard irq select not cleared by soft reset");

    a_kbd_irq_hard: assert property (hm_rst |=> slot_q[S_KBD_IRQ] == `RV_ZERO) // [RL1]
        else $error("keyboard irq select not cleared by hard reset");

    a_ptr_irq_reset: assert property ( // [RL2]
        (hm_rst || soft_pulse) |=> slot_q[S_PTR_IRQ] == `RV_ZERO)
        else $error("pointer irq select not cleared");

    a_ir_timeout_load: assert property (hm_rst |=> slot_q[S_IR_TMO] == `RV_IR_TIMEOUT) // [RL3]
        else $error("infrared timeout not reloaded");

    a_ir_timeout_keep: assert property ( // [RL3]
        (soft_pulse && !hm_rst && !slot_we[S_IR_TMO])
        |=> slot_q[S_IR_TMO] == $past(slot_q[S_IR_TMO]))
        else $error("infrared timeout lost on soft reset");

    a_routing_hold: assert property ( // [RL4]
        (hm_rst && !slot_we[S_ROUTE1])
        |=> $stable(slot_q[S_ROUTE1]))
        else $error("routing register changed without standby reset");

    a_routing2_hold: assert property ( // [RL4]
        ((hm_rst || soft_pulse) && !slot_we[S_ROUTE2])
        |=> $stable(slot_q[S_ROUTE2]))
        else $error("second routing register changed without standby reset");

    a_window_locked: assert property ( // [RL6]
        (data_wr && slot_hit[S_WIN0_HI]
        && slot_q[S_WIN0_LO][`BIT_WRITE_LOCK] && !hm_rst && !soft_pulse)
        |=> $stable(slot_q[S_WIN0_HI]))
        else $error("locked window accepted a write");

    a_win_lo_locked: assert property ( // [RL6]
        (data_wr && slot_hit[S_WIN0_LO]
        && slot_q[S_WIN0_LO][`BIT_WRITE_LOCK] && !hm_rst && !soft_pulse)
        |=> $stable(slot_q[S_WIN0_LO]))
        else $error("locked window low byte accepted a write");

    a_lock_soft_keep: assert property ( // [RL7]
        (soft_pulse && !hm_rst && !slot_we[S_WIN0_LO])
        |=> slot_q[S_WIN0_LO][`BIT_WRITE_LOCK] == $past(slot_q[S_WIN0_LO][`BIT_WRITE_LOCK]))
        else $error("lock bit changed on soft reset");

    a_xbus_bit7: assert property (i_hard_rst |=> !slot_q[S_XBUS_SEL][7]) // [RL8]
        else $error("expansion select bit7 survived hard reset");

    a_xbus_main: assert property ( // [RL8]
        i_main_por |=> (slot_q[S_XBUS_SEL] & `MASK_BIT7) == `RV_ZERO)
        else $error("expansion select bit7 survived main power-on reset");

    a_reserved_zero: assert property ( // [RL9]
        (data_rd && index >= `IDX_DEV_FIRST && !(|slot_hit))
        |=> o_rdata == `RV_ZERO)
        else $error("reserved location read nonzero");

    a_run_blocks: assert property ( // [RL10]
        (state == ST_RUN && !hm_rst && !soft_pulse)
        |=> $stable(slot_q) && $stable(ldn))
        else $error("register changed outside configuration mode");

    a_ldn_select: assert property ( // [RL11]
        (data_wr && index == `IDX_LDN && !hm_rst && !soft_pulse)
        |=> ldn == $past(i_wdata))
        else $error("device number not taken");

    a_soft_clears: assert property ( // [RL12]
        (data_wr && index == `IDX_CFG_CTRL && i_wdata[`BIT_SOFT_RESET] && !hm_rst)
        |=> soft_pulse ##1 !soft_pulse)
        else $error("soft reset not a single pulse");

    a_ldn_soft: assert property ((soft_pulse && !hm_rst) |=> ldn == `LD_FLOPPY) // [RL12]
        else $error("device number kept through soft reset");

    a_ctrl_reads_zero: assert property ( // [RL12]
        (data_rd && index == `IDX_CFG_CTRL)
        |=> o_rdata == `RV_ZERO)
        else $error("soft reset bit read back as set");

    c_enter_config: cover property (state == ST_RUN ##1 state == ST_CONFIG);
    c_window_lock: cover property (data_wr && slot_hit[S_WIN0_HI] && win_lock[1]);
    c_soft_reset: cover property (soft_pulse);
    c_kbd_read: cover property (data_rd && slot_hit[S_PTR_IRQ]);
    c_hard_reset: cover property (hm_rst ##1 state == ST_RUN);

endmodule : logical_device_config_bank

// ==== common/ldcfg_defs.svh ====
// constants of the logical device configuration bank
`ifndef LDCFG_DEFS_SVH
`define LDCFG_DEFS_SVH

`define NUM_SLOTS       45
`define NUM_LDN         16
`define NUM_WINDOWS     4

`define PORT_INDEX      1'b0
`define PORT_DATA       1'b1
`define KEY_ENTER       8'h55
`define KEY_EXIT        8'hAA

`define IDX_CFG_CTRL    8'h02
`define IDX_LDN         8'h07
`define IDX_DEV_ID      8'h20
`define IDX_DEV_REV     8'h21
`define IDX_DEV_FIRST   8'h30
`define IDX_ACTIVATE    8'h30
`define IDX_BASE0_HI    8'h60
`define IDX_BASE0_LO    8'h61
`define IDX_BASE1_HI    8'h62
`define IDX_BASE1_LO    8'h63
`define IDX_BASE2_HI    8'h64
`define IDX_BASE2_LO    8'h65
`define IDX_BASE3_HI    8'h66
`define IDX_BASE3_LO    8'h67
`define IDX_IRQ1        8'h70
`define IDX_IRQ2        8'h72
`define IDX_DMA         8'h74
`define IDX_MODE        8'hF0
`define IDX_MODE2       8'hF1
`define IDX_IR_TIMEOUT  8'hF2
`define IDX_OPT_A       8'hF4
`define IDX_OPT_B       8'hF5

`define LD_FLOPPY       8'h00
`define LD_PARALLEL     8'h03
`define LD_SERIAL1      8'h04
`define LD_SERIAL2      8'h05
`define LD_KEYBOARD     8'h07
`define LD_EXPANSION    8'h08
`define LD_RUNTIME      8'h0A
`define LD_SYSMGMT      8'h0B

`define RV_ZERO         8'h00
`define RV_DMA_PAR      8'h04
`define RV_PAR_MODE     8'h3C
`define RV_IR_OPTIONS   8'h02
`define RV_IR_TIMEOUT   8'h03

`define MASK_ALL        8'hFF
`define MASK_NONE       8'h00
`define MASK_LOW_SOFT   8'hFD
`define MASK_BIT7       8'h80

`define BIT_SOFT_RESET  0
`define BIT_ACTIVE      0
`define BIT_WRITE_LOCK  1
`define WIN_NONE        3'h0

`endif

// ==== common/ldcfg_pkg.sv ====
// types of the logical device configuration bank
package ldcfg_pkg;

    typedef enum logic [0:0] {
        ST_RUN    = 1'b0,
        ST_CONFIG = 1'b1
    } cfg_state_e;

    // one storage slot: owner device, index, reset value, reset masks, lock window
    typedef struct packed {
        logic [7:0] ldn;
        logic [7:0] idx;
        logic [7:0] rst;
        logic [7:0] hm_mask;
        logic [7:0] soft_mask;
        logic [2:0] win;
    } slot_s;

endpackage : ldcfg_pkg

// ==== bench/logical_device_config_bank_bench.sv ====
// self-checking bench for the logical device configuration bank
`timescale 1ns/10ps
`include "ldcfg_defs.svh"

module logical_device_config_bank_bench;
    import ldcfg_pkg::*;

    localparam logic [7:0] ID_VAL = 8'h5A;  // arbitrary value

    logic               i_clk_sys;
    logic               i_nrst;
    logic               i_main_por;
    logic               i_hard_rst;
    logic               i_wr;
    logic               i_rd;
    logic               i_port_sel;
    logic [7:0]         i_wdata;
    logic [7:0]         o_rdata;
    logic               o_config_mode;
    logic               o_soft_reset;
    logic [7:0]         o_ldn;
    logic [`NUM_LDN-1:0] o_active;
    logic [`NUM_SLOTS*8-1:0] o_slot_values;
    logic [7:0]         exp_v;
    int                 err_total;
    int                 total_checks;
    bit                 seen;

    // ldn, index, value written, value after soft reset, value after hard/main reset
    logic [39:0] tbl [10] = '{40'h07_70_5A_00_00, 40'h07_72_6B_00_00, 40'h05_F2_11_11_03,
        40'h0A_F4_33_33_33, 40'h0A_F5_44_44_44, 40'h08_F0_FF_FF_7F, 40'h08_60_12_00_00,
        40'h08_61_03_02_00, 40'h03_F0_55_55_3C, 40'h03_74_07_04_04};
    // ldn, index, value after standby reset
    logic [23:0] rv [10] = '{24'h03_74_04, 24'h03_F0_3C, 24'h05_F1_02, 24'h05_F2_03,
        24'h07_70_00, 24'h07_72_00, 24'h08_F0_00, 24'h0A_F4_00, 24'h00_F4_00, 24'h0B_70_00};
    // ldn, reserved or absent index
    logic [15:0] rsv [6] = '{16'h00_03, 16'h00_25, 16'h00_10, 16'h01_30, 16'h07_60, 16'h0A_70};

    logical_device_config_bank #(.DEVICE_ID(ID_VAL), .DEVICE_REV(8'h01)) i_dut (
        .i_clk_sys     (i_clk_sys),
        .i_nrst        (i_nrst),
        .i_main_por    (i_main_por),
        .i_hard_rst    (i_hard_rst),
        .i_wr          (i_wr),
        .i_rd          (i_rd),
        .i_port_sel    (i_port_sel),
        .i_wdata       (i_wdata),
        .o_rdata       (o_rdata),
        .o_config_mode (o_config_mode),
        .o_soft_reset  (o_soft_reset),
        .o_ldn         (o_ldn),
        .o_active      (o_active),
        .o_slot_values (o_slot_values)
    );

    initial begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask : chk

    // strobes are dropped a full cycle later, so back to back calls never collide
    task automatic wr(input logic p, input logic [7:0] d);
        @(negedge i_clk_sys);
        i_wr = 1'b1;
        i_port_sel = p;
        i_wdata = d;
        @(negedge i_clk_sys);
        i_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic p, input logic [7:0] exp);
        @(negedge i_clk_sys);
        i_rd = 1'b1;
        i_port_sel = p;
        @(negedge i_clk_sys);
        i_rd = 1'b0;
        chk(o_rdata, exp);
    endtask : rd

    task automatic setr(input logic [7:0] ld, input logic [7:0] idx, input logic [7:0] v);
        wr(`PORT_INDEX, `IDX_LDN);
        wr(`PORT_DATA, ld);
        wr(`PORT_INDEX, idx);
        wr(`PORT_DATA, v);
    endtask : setr

    task automatic getr(input logic [7:0] ld, input logic [7:0] idx, input logic [7:0] exp);
        wr(`PORT_INDEX, `IDX_LDN);
        wr(`PORT_DATA, ld);
        wr(`PORT_INDEX, idx);
        rd(`PORT_DATA, exp);
    endtask : getr

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    initial begin
        i_nrst = 1'b0;
        i_main_por = 1'b0;
        i_hard_rst = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_port_sel = 1'b0;
        i_wdata = 8'h00;
        err_total = 0;
        total_checks = 0;
        repeat (10) @(negedge i_clk_sys);
        i_nrst = 1'b1;
        // run state hides the data port
        rd(`PORT_DATA, 8'h00);
        chk(o_slot_values[167:160], `RV_IR_TIMEOUT);
        wr(`PORT_INDEX, `KEY_ENTER);
        chk(o_config_mode, 1'b1);
        for (int k = 0; k < 10; k++) getr(rv[k][23:16], rv[k][15:8], rv[k][7:0]);
        $display("test reset values done");
        for (int k = 0; k < 8; k++) setr(`LD_EXPANSION, 8'h60 + k, {4'(k), 4'h1});
        for (int k = 0; k < 8; k++) getr(`LD_EXPANSION, 8'h60 + k, {4'(k), 4'h1});
        chk(o_ldn, `LD_EXPANSION);
        setr(`LD_KEYBOARD, `IDX_ACTIVATE, 8'h01);
        chk(o_active, 16'h0080);
        for (int k = 0; k < 6; k++) setr(rsv[k][15:8], rsv[k][7:0], 8'hFF);
        for (int k = 0; k < 6; k++) getr(rsv[k][15:8], rsv[k][7:0], 8'h00);
        getr(`LD_FLOPPY, `IDX_DEV_ID, ID_VAL);
        getr(`LD_FLOPPY, `IDX_DEV_REV, 8'h01);
        wr(`PORT_INDEX, `IDX_IRQ2);
        rd(`PORT_INDEX, `IDX_IRQ2);
        $display("test access paths done");
        // r 0 soft, 1 hard, 2 main power-on
        for (int r = 0; r < 3; r++) begin
            for (int k = 0; k < 10; k++) setr(tbl[k][39:32], tbl[k][31:24], tbl[k][23:16]);
            if (r == 0) begin
                wr(`PORT_INDEX, `IDX_CFG_CTRL);
                wr(`PORT_DATA, 8'h01);
                seen = 1'b0;
                // soft pulse within a bounded wait
                for (int n = 0; n < 4 && !seen; n++) begin
                    if (o_soft_reset === 1'b1) seen = 1'b1;
                    else @(negedge i_clk_sys);
                end
                if (!seen) begin
                    err_total++;
                    final_report();
                end
                @(negedge i_clk_sys);
                chk(o_soft_reset, 1'b0);
                @(negedge i_clk_sys);
                chk(o_ldn, 8'h00);
                chk(o_config_mode, 1'b1);
                rd(`PORT_DATA, 8'h00);
            end else begin
                @(negedge i_clk_sys);
                if (r == 1) i_hard_rst = 1'b1;
                else i_main_por = 1'b1;
                @(negedge i_clk_sys);
                i_hard_rst = 1'b0;
                i_main_por = 1'b0;
                chk(o_config_mode, 1'b0);
                chk(o_active, 16'h0000);
                wr(`PORT_INDEX, `KEY_ENTER);
            end
            for (int k = 0; k < 10; k++) begin
                exp_v = (r == 0) ? tbl[k][15:8] : tbl[k][7:0];
                getr(tbl[k][39:32], tbl[k][31:24], exp_v);
            end
            if (r == 0) begin
                // window 0 stays locked after soft reset
                setr(`LD_EXPANSION, `IDX_BASE0_HI, 8'h77);
                setr(`LD_EXPANSION, `IDX_BASE0_LO, 8'h00);
                getr(`LD_EXPANSION, `IDX_BASE0_HI, 8'h00);
                getr(`LD_EXPANSION, `IDX_BASE0_LO, 8'h02);
            end
            $display("test reset source %0d done", r);
        end
        // writes in run state must not land
        setr(`LD_KEYBOARD, `IDX_IRQ1, 8'h21);
        wr(`PORT_INDEX, `KEY_EXIT);
        wr(`PORT_DATA, 8'h99);
        rd(`PORT_INDEX, 8'h00);
        wr(`PORT_INDEX, `KEY_ENTER);
        getr(`LD_KEYBOARD, `IDX_IRQ1, 8'h21);
        // standby reset in mid-run
        setr(`LD_RUNTIME, `IDX_OPT_A, 8'h33);
        setr(`LD_EXPANSION, `IDX_MODE, 8'hFF);
        @(negedge i_clk_sys);
        i_nrst = 1'b0;
        repeat (3) @(negedge i_clk_sys);
        i_nrst = 1'b1;
        chk(o_config_mode, 1'b0);
        wr(`PORT_INDEX, `KEY_ENTER);
        getr(`LD_RUNTIME, `IDX_OPT_A, 8'h00);
        getr(`LD_RUNTIME, `IDX_OPT_B, 8'h00);
        chk(o_slot_values[319:312], `RV_ZERO);
        getr(`LD_EXPANSION, `IDX_MODE, 8'h00);
        $display("test standby reset done");
        final_report();
    end
endmodule : logical_device_config_bank_bench
